// ===== src/ptp_adj_pkg.sv
// Constants, register map and carrier types for the time clock adjust block.
// Assumes a single 200 MHz core clock and a 10 ns reference tick derived from it.
package ptp_adj_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] TEMP_RATE_TRIM_OFS = 12'h120;
    localparam logic [ADDR_W-1:0] TEMP_RATE_CYCLES_OFS = 12'h124;
    localparam logic [ADDR_W-1:0] CLOCK_STEP_OFS = 12'h128;
    localparam logic [ADDR_W-1:0] TARGET_A_SECONDS_OFS = 12'h12c;
    localparam logic [ADDR_W-1:0] TARGET_A_NANOSECONDS_OFS = 12'h130;
    localparam logic [ADDR_W-1:0] TARGET_B_SECONDS_OFS = 12'h13c;
    localparam logic [ADDR_W-1:0] TARGET_B_NANOSECONDS_OFS = 12'h140;
    localparam logic [ADDR_W-1:0] TIME_COMMAND_CONTROL_OFS = 12'h180;
    localparam logic [ADDR_W-1:0] ADJUST_STATUS_OFS = 12'h184;
    localparam logic [ADDR_W-1:0] TIME_SECONDS_OFS = 12'h188;
    localparam logic [ADDR_W-1:0] TIME_NANOSECONDS_OFS = 12'h18c;

    // Field layout.
    localparam int DIR_BIT = 31;
    localparam int AMOUNT_W = 30;
    localparam int SEC_STEP_W = 4;
    localparam logic [DATA_W-1:0] DIR_AMOUNT_MASK = 32'hbfffffff;
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;

    // Command bits (self clearing) and status bits.
    localparam int CMD_STEP_SECONDS = 0;
    localparam int CMD_STEP_NANOSECONDS = 1;
    localparam int CMD_TRIM_START = 2;
    localparam int CMD_TARGET_READ = 3;
    localparam int STAT_TRIM_ACTIVE = 0;
    localparam int STAT_HIT_A = 1;
    localparam int STAT_HIT_B = 2;

    // Timing.
    localparam int REF_PERIOD_NS = 10;
    localparam int CORE_CLK_MHZ = 200;
    localparam int REF_TICK_CYCLES = REF_PERIOD_NS * CORE_CLK_MHZ / 1000;
    localparam logic [AMOUNT_W-1:0] NS_NORMAL = 30'h0000000a;
    localparam logic [AMOUNT_W-1:0] NS_SLOW = 30'h00000009;
    localparam logic [AMOUNT_W-1:0] NS_FAST = 30'h0000000b;
    localparam logic [AMOUNT_W-1:0] NS_PER_SEC = 30'h3b9aca00;

    typedef struct packed {
        logic [31:0] seconds;
        logic [AMOUNT_W-1:0] nanoseconds;
        logic [31:0] subns;
    } ptp_time_t;

    typedef struct packed {
        logic [31:0] target_seconds;
        logic [AMOUNT_W-1:0] target_nanoseconds;
    } target_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } bus_req_t;

    typedef enum logic {TRIM_IDLE, TRIM_RUN} trim_state_t;

endpackage

// ===== src/ptp_clock_adjust_and_target.sv
// Time clock with temporary rate trim, one-time step and two compare targets.
// Assumes a register master on the core clock that obeys the one-cycle strobes.
//
// Behaviour
// RULE1 - Each 10 ns reference tick adds 10 ns when no trim carry occurs.
// RULE2 - Trim bit 31 picks direction: 0 gives 9 ns, 1 gives 11 ns.
// RULE3 - While trimming, add 30-bit trim amount to sub-nanoseconds each tick.
// RULE4 - Sub-nanosecond wrap changes that tick's increment by 1 ns in trim direction.
// RULE5 - Trim stays active for the programmed count of reference cycles.
// RULE6 - Count down once per tick; at zero stop trimming and resume normal.
// RULE7 - One-time step applies to seconds or nanoseconds with amount and direction.
// RULE8 - Step bit 31: 0 subtracts, 1 adds.
// RULE9 - Software requests only additive steps for the nanoseconds part.
// RULE10 - Nanosecond step adds the 30-bit amount instead of the usual increment.
// RULE11 - Seconds step uses only the low four bits of the amount.
// RULE12 - A command bit picks seconds or nanoseconds; nanosecond overflow carries.
// RULE13 - Two targets compare with the running clock and flag a match.
// RULE14 - New target applies only after both halves are written.
// RULE15 - Target seconds reads return the snapshot taken by target-read.
// RULE16 - Target-read overwrites pending written target values with the active target.
// RULE17 - Software avoids target-read between writing the two halves.
// RULE18 - Software keeps reload/add mode at zero before writing targets.
// RULE19 - Clock holds 32-bit seconds, 30-bit nanoseconds, 32-bit sub-nanoseconds.
// RULE20 - Target nanoseconds is a 30-bit half paired with the seconds half.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ptp_clock_adjust_and_target #(
    parameter int TICK_W = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Register port
    input wire ptp_adj_pkg::bus_req_t i_bus,
    output logic [ptp_adj_pkg::DATA_W-1:0] o_rdata,
    // Time and events
    output ptp_adj_pkg::ptp_time_t o_time,
    output logic [1:0] o_target_hit,
    output logic o_trim_active
);

    typedef struct packed {
        ptp_adj_pkg::ptp_time_t tm;
        logic [31:0] trim;
        logic [31:0] cycles;
        logic [31:0] step;
        ptp_adj_pkg::target_t [1:0] staged;
        ptp_adj_pkg::target_t [1:0] active;
        logic [1:0] pend_sec;
        logic [1:0] pend_ns;
        logic [1:0] armed;
        logic [1:0] sticky_hit;
        logic [1:0] hit;
        ptp_adj_pkg::trim_state_t trim_st;
        logic [31:0] trim_left;
        logic step_sec_req;
        logic step_ns_req;
        logic [TICK_W-1:0] tick_cnt;
        logic [ptp_adj_pkg::DATA_W-1:0] rdata;
    } state_t;

    typedef struct packed {
        logic [1:0] carry;
        logic [ptp_adj_pkg::AMOUNT_W-1:0] ns;
    } ns_sum_t;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(ptp_adj_pkg::REF_TICK_CYCLES - 1);

    // Adds an increment and folds up to two whole seconds out of the result.
    function automatic ns_sum_t ns_add(input logic [29:0] ns, input logic [29:0] inc);
        logic [30:0] sum;
        logic [30:0] one_sec;
        ns_sum_t r;
        sum = {1'b0, ns} + {1'b0, inc};
        one_sec = {1'b0, ptp_adj_pkg::NS_PER_SEC};
        if (sum >= (one_sec << 1))
        begin
            r.carry = 2'h2;
            r.ns = 30'(sum - (one_sec << 1));
        end
        else if (sum >= one_sec)
        begin
            r.carry = 2'h1;
            r.ns = 30'(sum - one_sec);
        end
        else
        begin
            r.carry = 2'h0;
            r.ns = sum[29:0];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    state_t q;
    state_t d;
    logic tick;
    logic sub_carry;
    logic [1:0] sec_carry;
    logic [ptp_adj_pkg::AMOUNT_W-1:0] inc;
    ns_sum_t ns_r;
    always_comb
    begin
        d = q;
        d.hit = 2'h0;
        d.rdata = ptp_adj_pkg::RESET_WORD;
        tick = (q.tick_cnt == TICK_LAST);
        d.tick_cnt = tick ? '0 : TICK_W'(q.tick_cnt + 1'b1);
        sub_carry = 1'b0;
        inc = ptp_adj_pkg::NS_NORMAL; // RULE1
        ns_r = ns_add(q.tm.nanoseconds, inc);
        sec_carry = 2'h0;

        if (tick)
        begin
            if (q.trim_st == ptp_adj_pkg::TRIM_RUN)
            begin
                // RULE3
                {sub_carry, d.tm.subns} = {1'b0, q.tm.subns} + {3'h0, q.trim[29:0]};
                if (sub_carry)
                begin
                    // RULE2 RULE4
                    inc = q.trim[ptp_adj_pkg::DIR_BIT] ? ptp_adj_pkg::NS_FAST
                                                       : ptp_adj_pkg::NS_SLOW;
                end
                d.trim_left = q.trim_left - 32'h1; // RULE5
                if (q.trim_left == 32'h1)
                begin
                    d.trim_st = ptp_adj_pkg::TRIM_IDLE; // RULE6
                end
            end
            if (q.step_ns_req)
            begin
                // Direction is ignored: only addition exists for nanoseconds.
                inc = q.step[29:0]; // RULE10
                d.step_ns_req = 1'b0;
            end
            ns_r = ns_add(q.tm.nanoseconds, inc);
            sec_carry = ns_r.carry;
            d.tm.nanoseconds = ns_r.ns;
            d.tm.seconds = q.tm.seconds + {30'h0, sec_carry}; // RULE12
            if (q.step_sec_req)
            begin
                // RULE7 RULE8 RULE11
                d.tm.seconds = q.step[ptp_adj_pkg::DIR_BIT]
                    ? d.tm.seconds + 32'(q.step[ptp_adj_pkg::SEC_STEP_W-1:0])
                    : d.tm.seconds - 32'(q.step[ptp_adj_pkg::SEC_STEP_W-1:0]);
                d.step_sec_req = 1'b0;
            end
        end

        if (i_bus.we)
        begin
            unique case (i_bus.addr)
                ptp_adj_pkg::TEMP_RATE_TRIM_OFS:
                    d.trim = i_bus.wdata & ptp_adj_pkg::DIR_AMOUNT_MASK;
                ptp_adj_pkg::TEMP_RATE_CYCLES_OFS:
                    d.cycles = i_bus.wdata;
                ptp_adj_pkg::CLOCK_STEP_OFS:
                    d.step = i_bus.wdata & ptp_adj_pkg::DIR_AMOUNT_MASK;
                ptp_adj_pkg::TARGET_A_SECONDS_OFS:
                begin
                    d.staged[0].target_seconds = i_bus.wdata;
                    d.pend_sec[0] = 1'b1;
                end
                ptp_adj_pkg::TARGET_A_NANOSECONDS_OFS:
                begin
                    d.staged[0].target_nanoseconds = i_bus.wdata[29:0]; // RULE20
                    d.pend_ns[0] = 1'b1;
                end
                ptp_adj_pkg::TARGET_B_SECONDS_OFS:
                begin
                    d.staged[1].target_seconds = i_bus.wdata;
                    d.pend_sec[1] = 1'b1;
                end
                ptp_adj_pkg::TARGET_B_NANOSECONDS_OFS:
                begin
                    d.staged[1].target_nanoseconds = i_bus.wdata[29:0]; // RULE20
                    d.pend_ns[1] = 1'b1;
                end
                ptp_adj_pkg::TIME_COMMAND_CONTROL_OFS:
                begin
                    // RULE12
                    if (i_bus.wdata[ptp_adj_pkg::CMD_STEP_SECONDS])
                    begin
                        d.step_sec_req = 1'b1;
                    end
                    if (i_bus.wdata[ptp_adj_pkg::CMD_STEP_NANOSECONDS])
                    begin
                        d.step_ns_req = 1'b1;
                    end
                    if (i_bus.wdata[ptp_adj_pkg::CMD_TRIM_START])
                    begin
                        // A zero count never starts the trim. RULE5
                        d.trim_left = q.cycles;
                        d.trim_st = (q.cycles != 32'h0) ? ptp_adj_pkg::TRIM_RUN
                                                        : ptp_adj_pkg::TRIM_IDLE;
                    end
                    if (i_bus.wdata[ptp_adj_pkg::CMD_TARGET_READ])
                    begin
                        d.staged = q.active; // RULE15 RULE16
                    end
                end
                ptp_adj_pkg::ADJUST_STATUS_OFS:
                begin
                    d.sticky_hit = q.sticky_hit &
                        ~i_bus.wdata[ptp_adj_pkg::STAT_HIT_B:ptp_adj_pkg::STAT_HIT_A];
                end
                default:
                begin
                end
            endcase
        end

        for (int ch = 0; ch < 2; ch++)
        begin
            if (d.pend_sec[ch] && d.pend_ns[ch])
            begin
                d.active[ch] = d.staged[ch]; // RULE14
                d.pend_sec[ch] = 1'b0;
                d.pend_ns[ch] = 1'b0;
                d.armed[ch] = 1'b1;
            end
            else if (q.armed[ch] && {d.tm.seconds, d.tm.nanoseconds} >= q.active[ch])
            begin
                // Equality is rarely hit with 9 to 11 ns steps, so crossing counts.
                d.hit[ch] = 1'b1; // RULE13
                d.armed[ch] = 1'b0;
            end
        end
        // A match in the cycle of its clear keeps the flag set.
        d.sticky_hit = d.sticky_hit | d.hit;

        if (i_bus.re)
        begin
            unique case (i_bus.addr)
                ptp_adj_pkg::TEMP_RATE_TRIM_OFS: d.rdata = q.trim;
                ptp_adj_pkg::TEMP_RATE_CYCLES_OFS: d.rdata = q.cycles;
                ptp_adj_pkg::CLOCK_STEP_OFS: d.rdata = q.step;
                ptp_adj_pkg::TARGET_A_SECONDS_OFS: d.rdata = q.staged[0].target_seconds;
                ptp_adj_pkg::TARGET_A_NANOSECONDS_OFS:
                    d.rdata = {2'h0, q.staged[0].target_nanoseconds};
                ptp_adj_pkg::TARGET_B_SECONDS_OFS: d.rdata = q.staged[1].target_seconds;
                ptp_adj_pkg::TARGET_B_NANOSECONDS_OFS:
                    d.rdata = {2'h0, q.staged[1].target_nanoseconds};
                ptp_adj_pkg::ADJUST_STATUS_OFS:
                    d.rdata = {29'h0, q.sticky_hit, q.trim_st == ptp_adj_pkg::TRIM_RUN};
                ptp_adj_pkg::TIME_SECONDS_OFS: d.rdata = q.tm.seconds;
                ptp_adj_pkg::TIME_NANOSECONDS_OFS: d.rdata = {2'h0, q.tm.nanoseconds};
                default: d.rdata = ptp_adj_pkg::RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
    assign o_rdata = q.rdata;
    assign o_time = q.tm; // RULE19
    assign o_target_hit = q.hit;
    assign o_trim_active = (q.trim_st == ptp_adj_pkg::TRIM_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_sync_n);

    property p_normal_inc;
        tick && q.trim_st == ptp_adj_pkg::TRIM_IDLE && !q.step_ns_req && !q.step_sec_req
            && sec_carry == 2'h0
        |=> q.tm.nanoseconds == $past(q.tm.nanoseconds) + ptp_adj_pkg::NS_NORMAL;
    endproperty
    a_normal_inc: assert property (p_normal_inc) else $error("normal tick not 10 ns"); // RULE1
    property p_fast_carry;
        tick && q.trim_st == ptp_adj_pkg::TRIM_RUN && sub_carry && q.trim[31]
            && !q.step_ns_req && sec_carry == 2'h0
        |=> q.tm.nanoseconds == $past(q.tm.nanoseconds) + ptp_adj_pkg::NS_FAST;
    endproperty
    a_fast_carry: assert property (p_fast_carry) else $error("fast carry not 11 ns"); // RULE2
    property p_slow_carry;
        tick && q.trim_st == ptp_adj_pkg::TRIM_RUN && sub_carry && !q.trim[31]
            && !q.step_ns_req && sec_carry == 2'h0
        |=> q.tm.nanoseconds == $past(q.tm.nanoseconds) + ptp_adj_pkg::NS_SLOW;
    endproperty
    a_slow_carry: assert property (p_slow_carry) else $error("slow carry not 9 ns"); // RULE4
    property p_subns_acc;
        tick && q.trim_st == ptp_adj_pkg::TRIM_RUN
        |=> q.tm.subns == 32'($past(q.tm.subns) + {2'h0, $past(q.trim[29:0])});
    endproperty
    a_subns_acc: assert property (p_subns_acc) else $error("sub-ns sum wrong"); // RULE3
    property p_trim_end;
        tick && q.trim_st == ptp_adj_pkg::TRIM_RUN && q.trim_left == 32'h1 && !i_bus.we
        |=> !o_trim_active ##1 !o_trim_active;
    endproperty
    a_trim_end: assert property (p_trim_end) else $error("trim did not stop"); // RULE6
    property p_trim_holds;
        o_trim_active && q.trim_left > 32'h1 |=> o_trim_active;
    endproperty
    a_trim_holds: assert property (p_trim_holds) else $error("trim ended early"); // RULE5
    property p_step_sec;
        tick && q.step_sec_req && !q.step_ns_req && sec_carry == 2'h0
        |=> q.tm.seconds == ($past(q.step[31]) ?
            $past(q.tm.seconds) + {28'h0, $past(q.step[3:0])} :
            $past(q.tm.seconds) - {28'h0, $past(q.step[3:0])});
    endproperty
    a_step_sec: assert property (p_step_sec) else $error("seconds step wrong"); // RULE11
    property p_step_ns;
        tick && q.step_ns_req && sec_carry == 2'h0
        |=> q.tm.nanoseconds == $past(q.tm.nanoseconds) + $past(q.step[29:0]);
    endproperty
    a_step_ns: assert property (p_step_ns) else $error("ns step wrong"); // RULE10
    property p_half_write;
        i_bus.we && i_bus.addr == ptp_adj_pkg::TARGET_A_SECONDS_OFS && !q.pend_ns[0]
        |=> q.active[0] == $past(q.active[0]);
    endproperty
    a_half_write: assert property (p_half_write) else $error("half write applied"); // RULE14
    property p_target_read;
        i_bus.we && i_bus.addr == ptp_adj_pkg::TIME_COMMAND_CONTROL_OFS
            && i_bus.wdata[ptp_adj_pkg::CMD_TARGET_READ]
        |=> q.staged == $past(q.active);
    endproperty
    a_target_read: assert property (p_target_read) else $error("snapshot missing"); // RULE16
    property p_hit_valid;
        o_target_hit[0] |-> {o_time.seconds, o_time.nanoseconds} >= q.active[0];
    endproperty
    a_hit_valid: assert property (p_hit_valid) else $error("hit before target"); // RULE13
    c_trim_done: cover property (o_trim_active ##1 !o_trim_active);
    c_hit_a: cover property (o_target_hit[0]);
    c_sec_step: cover property (tick && q.step_sec_req);

endmodule

`default_nettype wire

// ===== test/tb_ptp_clock_adjust_and_target.sv
// Self-checking testbench for the time clock adjust and target block.
// Assumes the register map and the 2-cycle reference tick of the design package.
`timescale 1ns/1ps
`default_nettype none

module tb_ptp_clock_adjust_and_target;

    logic i_core_clk;
    logic i_rst_n;
    ptp_adj_pkg::bus_req_t bus;
    logic [31:0] o_rdata;
    ptp_adj_pkg::ptp_time_t o_time;
    logic [1:0] o_target_hit;
    logic o_trim_active;
    int bad_count;
    int tests_run;
    localparam logic [63:0] NS_SEC = 64'h3b9aca00;

    ptp_clock_adjust_and_target u_dut (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_bus(bus),
        .o_rdata(o_rdata),
        .o_time(o_time),
        .o_target_hit(o_target_hit),
        .o_trim_active(o_trim_active)
    );

    initial i_core_clk = 1'b0;
    always #2.5 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [63:0] to_ns(ptp_adj_pkg::ptp_time_t t);
        return 64'(t.seconds) * NS_SEC + 64'(t.nanoseconds);
    endfunction

    task automatic chk_word(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_time(logic [63:0] got, logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_core_clk);
        bus.we <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: 32'h00000000, we: 1'b0, re: 1'b1};
        @(posedge i_core_clk);
        bus.re <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rd_chk(logic [11:0] a, logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk_word(d, exp);
    endtask

    // Waits on a settled edge until the channel pulses; returns the time seen then.
    task automatic wait_hit(int ch, int max, output logic [63:0] t, output int n);
        n = 0;
        t = '0;
        while (n < max)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
            if (o_target_hit[ch] === 1'b1)
            begin
                t = to_ns(o_time);
                break;
            end
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] w;
        logic [31:0] sa;
        logic [29:0] amt;
        logic [63:0] t0;
        logic [63:0] t1;
        logic [63:0] acc;
        logic [31:0] s0;
        logic [3:0] k;
        int n;
        logic [11:0] reg_ofs [7];
        bad_count = 0;
        tests_run = 0;
        i_rst_n = 1'b0;
        bus = '{addr: 12'h000, wdata: 32'h00000000, we: 1'b0, re: 1'b0};
        void'($urandom(32'h633fdcfe));
        repeat (5) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);

        // Reset values, then write and read back with reserved bits dropped.
        reg_ofs = '{12'h120, 12'h124, 12'h128, 12'h12c, 12'h130, 12'h13c, 12'h140};
        foreach (reg_ofs[i])
            rd_chk(reg_ofs[i], 32'h00000000);
        w = $urandom();
        wr(12'h120, w);
        rd_chk(12'h120, w & ptp_adj_pkg::DIR_AMOUNT_MASK);
        s0 = $urandom();
        wr(12'h124, s0);
        rd_chk(12'h124, s0);
        w = $urandom();
        wr(12'h128, w);
        rd_chk(12'h128, w & ptp_adj_pkg::DIR_AMOUNT_MASK);
        wr(12'h204, 32'hffffffff);
        rd_chk(12'h204, 32'h00000000);
        rd_chk(12'h124, s0);
        // Park both targets far in the future so they never fire by accident.
        // The reload/add mode is never switched on, so target writes are always legal.
        sa = $urandom() | 32'h80000000;
        wr(12'h12c, sa);
        wr(12'h130, 32'h00000005);
        rd_chk(12'h12c, sa);
        wr(12'h13c, sa ^ 32'h0000ffff);
        wr(12'h140, 32'hc0000007);
        rd_chk(12'h140, 32'h00000007);
        // A staged seconds value is replaced by the active one on target-read.
        wr(12'h12c, $urandom() & 32'h7fffffff);
        wr(12'h180, 32'h00000008);
        rd_chk(12'h12c, sa);
        wr(12'h130, 32'h00000005);

        // Plain rate: 20 core cycles are 10 reference ticks.
        @(posedge i_core_clk);
        #1;
        t0 = to_ns(o_time);
        repeat (20) @(posedge i_core_clk);
        #1;
        chk_time(to_ns(o_time), t0 + 64'h64);

        // Temporary trim in both directions, random amount and length.
        for (int dir = 0; dir < 2; dir++)
        begin
            amt = 30'($urandom());
            n = 3 + $urandom_range(17);
            wr(12'h120, {dir[0], 1'b0, amt});
            wr(12'h124, 32'(n));
            @(posedge i_core_clk);
            #1;
            t0 = to_ns(o_time);
            s0 = o_time.subns;
            acc = 64'(s0) + 64'(n) * 64'(amt);
            wr(12'h180, 32'h00000004);
            @(posedge i_core_clk);
            #1;
            chk_word(32'(o_trim_active), 32'h00000001);
            repeat (57) @(posedge i_core_clk);
            #1;
            chk_word(32'(o_trim_active), 32'h00000000);
            chk_word(o_time.subns, acc[31:0]);
            if (dir == 1)
                chk_time(to_ns(o_time), t0 + 64'h12c + (acc >> 32));
            else
                chk_time(to_ns(o_time), t0 + 64'h12c - (acc >> 32));
        end

        // Nanosecond steps, the largest amount first, carrying into seconds.
        for (int i = 0; i < 2; i++)
        begin
            amt = (i == 0) ? 30'h3fffffff : 30'($urandom());
            wr(12'h128, {2'b10, amt});
            @(posedge i_core_clk);
            #1;
            t0 = to_ns(o_time);
            wr(12'h180, 32'h00000002);
            repeat (18) @(posedge i_core_clk);
            #1;
            chk_time(to_ns(o_time), t0 + 64'h5a + 64'(amt));
        end

        // Seconds steps: add 15 then subtract a random count; upper amount bits are noise.
        for (int i = 0; i < 2; i++)
        begin
            k = (i == 0) ? 4'hf : 4'($urandom());
            wr(12'h128, {i == 0, 1'b0, 26'($urandom()), k});
            @(posedge i_core_clk);
            #1;
            t0 = to_ns(o_time);
            wr(12'h180, 32'h00000001);
            repeat (18) @(posedge i_core_clk);
            #1;
            if (i == 0)
                chk_time(to_ns(o_time), t0 + 64'h64 + 64'(k) * NS_SEC);
            else
                chk_time(to_ns(o_time), t0 + 64'h64 - 64'(k) * NS_SEC);
        end

        // Channel A fires once when the clock reaches the new target.
        t0 = to_ns(o_time) + 64'h190 + 64'($urandom_range(50));
        wr(12'h130, 32'(t0 % NS_SEC));
        wr(12'h12c, 32'(t0 / NS_SEC));
        wait_hit(0, 200, t1, n);
        chk_word(32'(t1 >= t0 && t1 < t0 + 64'ha), 32'h00000001);
        wait_hit(0, 100, t1, n);
        chk_word(32'(n), 32'h64);
        chk_time(t1, 64'h0);

        // Channel B: one half alone does nothing; the second half commits a past target.
        t0 = to_ns(o_time) + 64'h64;
        wr(12'h13c, 32'(t0 / NS_SEC));
        wait_hit(1, 150, t1, n);
        chk_word(32'(n), 32'h96);
        chk_time(t1, 64'h0);
        wr(12'h140, 32'(t0 % NS_SEC));
        wait_hit(1, 10, t1, n);
        chk_word(32'(n < 10), 32'h00000001);
        rd_chk(12'h13c, 32'(t0 / NS_SEC));

        end_of_test();
    end

endmodule

`default_nettype wire
